// ### core/interrupt_vector_and_trap_logic.sv
// Interrupt source vectoring, trap flag register and hardware trap dispatch.
//
// Behaviour
// - A trap is offered at once, unmasked, at its own vector; the five class B causes share vector 028h.
// - Each trap sets its own bit in the trap flag register.
// - A trap preempts anything except a trap service of equal or higher priority in progress.
// - During trap service no ordinary request is offered.
// - Capture/compare channel 31 has request and enable flags; vector 0118h, trap 46h.
// - Control bits 7 to 0 hold flags and levels; upper byte reads zero.
// - Servicing a trap forces the CPU priority level to 15.
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/100ps
module interrupt_vector_and_trap_logic (
   input wire logic core_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; all state holds while low.
   input wire logic cyc_i, // Wishbone cycle.
   input wire logic stb_i, // Wishbone strobe.
   input wire logic we_i, // Wishbone write enable.
   input wire logic [ivt_pkg::AdrW-1:0] adr_i, // Wishbone byte address.
   input wire logic [31:0] dat_i, // Wishbone write data.
   input wire logic [3:0] sel_i, // Wishbone byte selects.
   output logic [31:0] dat_o, // Wishbone read data.
   output logic ack_o, // Wishbone acknowledge.
   input wire logic [ivt_pkg::NumSrc-1:0] srcEvent, // Peripheral request pulses.
   input wire logic [ivt_pkg::NumTrap-1:0] trapEvent, // Hardware trap condition pulses.
   input wire logic [3:0] cpuLevel, // Current CPU priority level.
   input wire logic intAck, // CPU takes the offered request.
   input wire logic trapDone, // CPU leaves the trap service.
   output logic intReq, // Request offered to the CPU.
   output logic [8:0] intVector, // Vector location of the offer.
   output logic [6:0] intTrapNum, // Trap number of the offer.
   output logic intIsTrap, // Offer is a hardware trap.
   output logic [3:0] intLevel, // Priority level the CPU loads on entry.
   output logic trapActive // A hardware trap service is running.
);
   typedef struct packed {
      logic [ivt_pkg::NumSrc-1:0][7:0] ctrl;
      logic [7:0] trap_flag_register;
      logic [7:0] pend;
      logic trapAct;
      logic [1:0] actRank;
      ivt_pkg::state_type st;
      logic offTrap;
      logic [ivt_pkg::SrcIdxW-1:0] offSrc;
      logic [ivt_pkg::TrapIdxW-1:0] offTrapIdx;
      logic [8:0] vec;
      logic [6:0] tnum;
      logic [3:0] lvl;
      logic ack;
      logic [31:0] rdat;
   } state_struct_type;

   // Which register a bus address falls on.
   typedef enum logic [1:0] {
      SelNone = 2'h0,
      SelCtrl = 2'h1,
      SelTfr = 2'h2,
      SelStat = 2'h3
   } reg_sel_type;

   state_struct_type s_r;
   state_struct_type s_nxt;
   logic [ivt_pkg::TrapIdxW-1:0] bestTrap;
   logic anyTrap;
   logic trapWins;
   logic wbReq;
   logic [9:0] wordIdx;
   logic [ivt_pkg::AdrW-1:0] ctrlOff;
   reg_sel_type regHit;

   arb_if arbBus ();

   source_arbiter arbiter (
      .port(arbBus.arb)
   );

   assign arbBus.ctrl = s_r.ctrl;
   assign arbBus.cpuLevel = cpuLevel;
   assign arbBus.block = s_r.trapAct;

   ////////////////////////////////////////////////////////////////////////////////////////

   // Pending traps are indexed in priority order, so the lowest set bit wins.
   function automatic logic [ivt_pkg::TrapIdxW:0] firstTrap(input logic [7:0] p);
      logic [ivt_pkg::TrapIdxW:0] r;
      r = '0;
      for (int i = ivt_pkg::NumTrap - 1; i >= 0; i--) begin
         if (p[i]) begin
            r = {1'b1, ivt_pkg::TrapIdxW'(i)};
         end
      end
      return r;
   endfunction : firstTrap

   // One decode serves the read and the write path, so the two can never disagree.
   function automatic reg_sel_type regSel(input logic [ivt_pkg::AdrW-1:0] a);
      logic [ivt_pkg::AdrW-1:0] rel;
      reg_sel_type r;
      rel = a - ivt_pkg::CtrlBase;
      r = SelNone;
      if (rel[ivt_pkg::AdrW-1:2] < 10'(ivt_pkg::NumSrc)) begin
         r = SelCtrl;
      end else if (a == ivt_pkg::TfrOff) begin
         r = SelTfr;
      end else if (a == ivt_pkg::StatOff) begin
         r = SelStat;
      end
      return r;
   endfunction : regSel

   // Priority level field of a control byte.
   function automatic logic [3:0] ctrlLevel(input logic [7:0] c);
      return c[ivt_pkg::IlvlLo +: 4];
   endfunction : ctrlLevel

   assign {anyTrap, bestTrap} = firstTrap(s_r.pend);
   assign trapWins = anyTrap &&
      (!s_r.trapAct || ivt_pkg::trapRank(bestTrap) > s_r.actRank);
   assign wbReq = cyc_i && stb_i && !s_r.ack;
   assign ctrlOff = adr_i - ivt_pkg::CtrlBase;
   assign wordIdx = ctrlOff[ivt_pkg::AdrW-1:2];
   assign regHit = regSel(adr_i);

   ////////////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = wbReq;
      s_nxt.rdat = 32'h0000_0000;
      // Register reads; the upper bits of every register read as zero.
      if (wbReq && !we_i) begin
         case (regHit)
            SelCtrl: begin
               s_nxt.rdat = {24'h00_0000, s_r.ctrl[5'(wordIdx)]};
            end
            SelTfr: begin
               s_nxt.rdat = {24'h00_0000, s_r.trap_flag_register};
            end
            SelStat: begin
               s_nxt.rdat = {16'h0000, 3'h0, s_r.trapAct, 2'h0, s_r.actRank, s_r.pend};
            end
            default: begin
               s_nxt.rdat = 32'h0000_0000;
            end
         endcase
      end
      // Register writes; only the low byte lane lands, the rest is discarded.
      if (wbReq && we_i && sel_i[0]) begin
         case (regHit)
            SelCtrl: begin
               s_nxt.ctrl[5'(wordIdx)] = dat_i[7:0];
            end
            SelTfr: begin
               // Writing zero clears a trap flag; writing one leaves it.
               s_nxt.trap_flag_register = s_r.trap_flag_register & dat_i[7:0];
            end
            default: begin
               // Status and unmapped addresses take no write.
            end
         endcase
      end
      if (trapDone) begin
         s_nxt.trapAct = 1'b0;
      end
      case (s_r.st)
         ivt_pkg::StIdle: begin
            if (trapWins) begin
               s_nxt.st = ivt_pkg::StOffer;
               s_nxt.offTrap = 1'b1;
               s_nxt.offTrapIdx = bestTrap;
               s_nxt.tnum = ivt_pkg::TrapTrapNum[bestTrap];
               s_nxt.vec = ivt_pkg::vecOf(ivt_pkg::TrapTrapNum[bestTrap]);
               s_nxt.lvl = ivt_pkg::MaxLevel;
            end else if (arbBus.found && !s_r.trapAct) begin
               s_nxt.st = ivt_pkg::StOffer;
               s_nxt.offTrap = 1'b0;
               s_nxt.offSrc = arbBus.winIdx;
               s_nxt.tnum = ivt_pkg::SrcTrapNum[arbBus.winIdx];
               s_nxt.vec = ivt_pkg::vecOf(ivt_pkg::SrcTrapNum[arbBus.winIdx]);
               s_nxt.lvl = ctrlLevel(s_r.ctrl[arbBus.winIdx]);
            end
         end
         ivt_pkg::StOffer: begin
            if (intAck) begin
               s_nxt.st = ivt_pkg::StIdle;
               if (s_r.offTrap) begin
                  s_nxt.pend[s_r.offTrapIdx] = 1'b0;
                  s_nxt.trapAct = 1'b1;
                  s_nxt.actRank = ivt_pkg::trapRank(s_r.offTrapIdx);
               end else begin
                  s_nxt.ctrl[s_r.offSrc][ivt_pkg::IrBit] = 1'b0;
               end
            end else if (!s_r.offTrap &&
                         (anyTrap || s_r.trapAct || !arbBus.found ||
                          arbBus.winIdx != s_r.offSrc)) begin
               // A pending trap or a changed winner withdraws an ordinary offer.
               s_nxt.st = ivt_pkg::StIdle;
            end
         end
         default: begin
            s_nxt.st = ivt_pkg::StIdle;
         end
      endcase
      // Hardware sets come last so that they win over any clear in the same cycle.
      for (int i = 0; i < ivt_pkg::NumSrc; i++) begin
         if (srcEvent[i]) begin
            s_nxt.ctrl[i][ivt_pkg::IrBit] = 1'b1;
         end
      end
      s_nxt.trap_flag_register = s_nxt.trap_flag_register | trapEvent;
      s_nxt.pend = s_nxt.pend | trapEvent;
   end

   ////////////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= {ivt_pkg::NumSrc{ivt_pkg::CtrlResetVal}};
         s_r.trap_flag_register <= ivt_pkg::TfrResetVal;
         s_r.st <= ivt_pkg::StIdle;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign dat_o = s_r.rdat;
   assign ack_o = s_r.ack;
   assign intReq = (s_r.st == ivt_pkg::StOffer);
   assign intVector = s_r.vec;
   assign intTrapNum = s_r.tnum;
   assign intIsTrap = s_r.offTrap;
   assign intLevel = s_r.lvl;
   assign trapActive = s_r.trapAct;
endmodule : interrupt_vector_and_trap_logic

// ### core/ivt_pkg.sv
// Shared constants, types and helpers for the interrupt vector and trap logic.
package ivt_pkg;
   // Peripheral sources, in table order; trap numbers below follow the same order.
   localparam int NumSrc = 27;
   localparam int NumTrap = 8;
   localparam int SrcIdxW = 5;
   localparam int TrapIdxW = 3;
   typedef logic [6:0] tnum_type;
   typedef logic [8:0] vec_type;
   localparam tnum_type SrcTrapNum [NumSrc] = '{
      7'h44, 7'h45, 7'h46, 7'h20, 7'h21, 7'h3D, 7'h3E, 7'h22, 7'h23, 7'h24,
      7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D,
      7'h2E, 7'h2F, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43};
   localparam int Capcom31Idx = 2;
   // Traps: non-maskable, stack overflow, stack underflow, then five class B causes.
   localparam tnum_type TrapTrapNum [NumTrap] = '{
      7'h02, 7'h04, 7'h06, 7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A};
   // Control register field positions and reset value.
   localparam int IrBit = 7;
   localparam int IeBit = 6;
   localparam int IlvlLo = 2;
   localparam int GlvlLo = 0;
   localparam logic [7:0] CtrlResetVal = 8'h00;
   localparam logic [7:0] TfrResetVal = 8'h00;
   localparam logic [3:0] MaxLevel = 4'hF;
   // Register map, byte addresses.
   localparam int AdrW = 12;
   localparam logic [AdrW-1:0] CtrlBase = 12'h000;
   localparam logic [AdrW-1:0] TfrOff = 12'h100;
   localparam logic [AdrW-1:0] StatOff = 12'h104;
   typedef enum logic [1:0] {
      StIdle = 2'b01,
      StOffer = 2'b10
   } state_type;

   // A vector location is four times the trap number.
   function automatic vec_type vecOf(input tnum_type tn);
      return {tn, 2'b00};
   endfunction : vecOf

   // Traps are indexed in priority order; the class B group shares the lowest rank.
   function automatic logic [1:0] trapRank(input logic [TrapIdxW-1:0] idx);
      return (idx < 3'h3) ? 2'(3 - int'(idx)) : 2'h0;
   endfunction : trapRank
endpackage : ivt_pkg

// ### core/arb_if.sv
// Carrier between the control registers and the priority arbiter.
`timescale 1ns/100ps
interface arb_if;
   logic [ivt_pkg::NumSrc-1:0][7:0] ctrl;
   logic [3:0] cpuLevel;
   logic block;
   logic found;
   logic [ivt_pkg::SrcIdxW-1:0] winIdx;
   modport regs (output ctrl, output cpuLevel, output block, input found, input winIdx);
   modport arb (input ctrl, input cpuLevel, input block, output found, output winIdx);
endinterface : arb_if

// ### core/source_arbiter.sv
// Combinational priority arbiter over the enabled, pending peripheral sources.
`timescale 1ns/100ps
module source_arbiter (
   arb_if.arb port // Control registers in, winner out.
);
   logic [5:0] bestKey;
   logic [5:0] key;

   always_comb begin
      bestKey = 6'h00;
      key = 6'h00;
      port.found = 1'b0;
      port.winIdx = '0;
      for (int i = 0; i < ivt_pkg::NumSrc; i++) begin
         key = port.ctrl[i][5:0];
         // Only a set request with its enable set, above the current CPU level, competes.
         if (!port.block && port.ctrl[i][ivt_pkg::IrBit] && port.ctrl[i][ivt_pkg::IeBit] &&
             key[5:2] > port.cpuLevel && (!port.found || key > bestKey)) begin
            port.found = 1'b1;
            port.winIdx = ivt_pkg::SrcIdxW'(i);
            bestKey = key;
         end
      end
   end
endmodule : source_arbiter

// ### tb/ivt_monitor.sv
// Port assertions for the interrupt vector and trap logic.
`timescale 1ns/100ps
module ivt_monitor (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic ce, // Enable.
   input wire logic cyc_i, // Cycle.
   input wire logic stb_i, // Strobe.
   input wire logic ack_o, // Ack.
   input wire logic [31:0] dat_o, // Data.
   input wire logic [ivt_pkg::NumTrap-1:0] trapEvent, // Traps.
   input wire logic intAck, // Taken.
   input wire logic intReq, // Offer.
   input wire logic [8:0] intVector, // Vector.
   input wire logic [6:0] intTrapNum, // Number.
   input wire logic intIsTrap, // Trap.
   input wire logic [3:0] intLevel, // Level.
   input wire logic trapActive // Service.
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_ack_one_cycle: assert property (ack_o && ce |=> !ack_o)
      else $error("ack too long");
   a_ack_on_time: assert property (cyc_i && stb_i && ce && !ack_o |=> ack_o)
      else $error("ack missing");
   a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("upper bits set");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("data outside ack");
   a_vec_four_times: assert property (intReq |-> intVector == {intTrapNum, 2'b00})
      else $error("vector mismatch");
   a_trap_level_max: assert property (intReq && intIsTrap |-> intLevel == 4'hF)
      else $error("trap level");
   a_trap_offer_fast: assert property (trapEvent != '0 && ce && !trapActive && !intReq
      |-> ##[1:4] (intReq && intIsTrap))
      else $error("trap late");
   a_trap_kept: assert property (intReq && intIsTrap && !intAck && ce
      |=> intReq && intIsTrap)
      else $error("trap withdrawn");
   a_no_ord_trap: assert property (trapActive |-> !intReq || intIsTrap)
      else $error("ordinary in trap");
   a_offer_stable: assert property (intReq && !intAck && ce |=> !intReq || $stable(intVector))
      else $error("offer changed");
   a_req_gap: assert property (intReq && intAck && ce |=> !intReq)
      else $error("no gap");
endmodule : ivt_monitor
bind interrupt_vector_and_trap_logic ivt_monitor u_mon (.core_clk(core_clk), .rst(rst),
   .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .trapEvent(trapEvent),
   .intAck(intAck), .intReq(intReq), .intVector(intVector), .intTrapNum(intTrapNum),
   .intIsTrap(intIsTrap), .intLevel(intLevel), .trapActive(trapActive));

// ### tb/cpu_model.sv
// Behavioural CPU core that takes offers and leaves trap services.
`timescale 1ns/100ps
module cpu_model (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic stall, // Hold off taking.
   input wire logic doneCmd, // Leave trap.
   input wire logic intReq, // Offer.
   output logic intAck, // Take pulse.
   output logic trapDone // End pulse.
);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         intAck <= 1'b0;
         trapDone <= 1'b0;
      end else begin
         intAck <= intReq && !intAck && !stall;
         trapDone <= doneCmd;
      end
   end
endmodule : cpu_model

// ### tb/tb_top.sv
// Self-checking bench for the interrupt vector and trap logic.
`timescale 1ns/100ps
module tb_top;
   typedef struct {int idx; logic [7:0] ctrl; logic [3:0] cpu; logic [8:0] vec;
      logic [6:0] tn; logic [3:0] lvl;} row_type;
   row_type rows [3] = '{'{2, 8'h54, 4'h0, 9'h118, 7'h46, 4'h5},
      '{16, 8'h7F, 4'hE, 9'h11C, 7'h47, 4'hF}, '{3, 8'h45, 4'h0, 9'h080, 7'h20, 4'h1}};
   logic core_clk, rst, ce, cyc, stb, we, ack, intAck, trapDone, intReq, intIsTrap;
   logic trapActive, stall, doneCmd, seen;
   logic [11:0] adr;
   logic [31:0] datI, datO, rd;
   logic [3:0] sel, cpuLevel, intLevel;
   logic [26:0] srcEvent;
   logic [7:0] trapEvent;
   logic [8:0] intVector;
   logic [6:0] intTrapNum;
   int badCount, testsRun;
   interrupt_vector_and_trap_logic u_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datI), .sel_i(sel),
      .dat_o(datO), .ack_o(ack), .srcEvent(srcEvent), .trapEvent(trapEvent),
      .cpuLevel(cpuLevel), .intAck(intAck), .trapDone(trapDone), .intReq(intReq),
      .intVector(intVector), .intTrapNum(intTrapNum), .intIsTrap(intIsTrap),
      .intLevel(intLevel), .trapActive(trapActive));
   cpu_model u_cpu (.core_clk(core_clk), .rst(rst), .stall(stall), .doneCmd(doneCmd),
      .intReq(intReq), .intAck(intAck), .trapDone(trapDone));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {cyc, stb, we, adr, datI} <= {2'b11, w, a, d};
      do @(posedge core_clk); while (ack !== 1'b1);
      rd = datO;
      {cyc, stb, we} <= 3'b000;
   endtask : wb
   task automatic ev(input logic [26:0] s, input logic [7:0] t);
      @(posedge core_clk);
      {srcEvent, trapEvent} <= {s, t};
      @(posedge core_clk);
      {srcEvent, trapEvent} <= '0;
   endtask : ev
   task automatic waitReq;
      seen = 1'b0;
      for (int i = 0; i < 6 && seen !== 1'b1; i++) begin
         @(posedge core_clk);
         seen = intReq;
      end
   endtask : waitReq
   task automatic done;
      @(posedge core_clk);
      doneCmd <= 1'b1;
      @(posedge core_clk);
      doneCmd <= 1'b0;
   endtask : done
   task automatic end_sim;
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      #2000000;
      badCount++;
      end_sim();
   end
   initial begin
      {rst, ce, cyc, stb, we, stall, doneCmd, adr, datI} = {7'b1100000, 44'h0};
      {sel, cpuLevel, srcEvent, trapEvent} = {4'hF, 39'h0};
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         cpuLevel <= rows[i].cpu;
         wb(1'b1, 12'(4 * rows[i].idx), {24'h00_0000, rows[i].ctrl});
         ev(27'(1) << rows[i].idx, 8'h00);
         waitReq();
         chk({seen, intIsTrap, intLevel, intTrapNum, intVector},
            {2'b10, rows[i].lvl, rows[i].tn, rows[i].vec});
         repeat (4) @(posedge core_clk);
         wb(1'b0, 12'(4 * rows[i].idx), 32'h0);
         chk(rd, {24'h00_0000, rows[i].ctrl});
      end
      $display("source rows done");
      wb(1'b1, 12'h004, 32'hABCD_12C0);
      wb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_00C0);
      wb(1'b0, 12'h200, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, 12'h00C, 32'h0000_0005);
      ev(27'h8, 8'h00);
      waitReq();
      chk(seen, 0);
      $display("register and mask tests done");
      stall <= 1'b1;
      ev('0, 8'h01);
      waitReq();
      chk({seen, intIsTrap, intLevel, intVector}, {2'b11, 4'hF, 9'h008});
      wb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h1);
      stall <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(trapActive, 1);
      wb(1'b1, 12'h008, 32'h0000_0054);
      ev(27'h4, 8'h02);
      waitReq();
      chk(seen, 0);
      done();
      waitReq();
      chk({seen, intIsTrap, intVector}, {2'b11, 9'h010});
      repeat (3) @(posedge core_clk);
      done();
      waitReq();
      chk({seen, intIsTrap, intVector}, {2'b10, 9'h118});
      wb(1'b1, 12'h100, 32'h2);
      wb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h2);
      $display("trap tests done");
      wb(1'b1, 12'h010, 32'h0000_0054);
      ce <= 1'b0;
      ev(27'h10, 8'h00);
      waitReq();
      chk(seen, 0);
      ce <= 1'b1;
      wb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0000_0054);
      $display("clock enable test done");
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      wb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
      end_sim();
   end
endmodule : tb_top
